// ---- src/drive_fieldbus_command_status_word.v ----
// Contract
// - command bit 8 with jogging enabled selects jog reference one.
// - command bit 9 with jogging enabled selects jog reference two.
// - main command word obeyed only while command bit 10 is set.
// - clearing bit 10 while running causes a coasting stop.
// - missing toggles of bit 11 past the delay cause a fault.
// - a zero watchdog delay disables pulse supervision entirely.
// - status bit 0 shows ready to switch on.
// - status bit 1 shows ready to run.
// - status bit 2 shows running and modulating.
// - status bit 3 shows fault state.
// - status bit 4 low while coasting stop is commanded.
// - status bit 5 low while quick stop is commanded.
// - inhibit clears only after stops released then off applied.
// - status bit 7 follows warning, no acknowledgement.
// - status bit 8 shows speed at reference within tolerance.
// - status bit 9 shows fieldbus control active.
// - status bit 10 shows speed above configured limit.
// - status bit 15 echoes command bit 11.
// - basic word bit 0 start, bit 1 direction.
// - basic word bit 2 rising edge resets faults.
// - basic word bits 3 to 7 pass out as bus inputs.
// - rising edge of on bit clears inhibit, goes ready to run.
`include "fieldbus_cmd_regs.vh"

module drive_fieldbus_command_status_word #(
   parameter REF_W = 16,
   parameter DW = 16
) (
   // clock and reset
   input wire clk,
   input wire reset_n,
   // fieldbus words (from the bus interface, asynchronous)
   input wire [15:0] commandWord,
   input wire [15:0] basicCommandWord,
   output wire [15:0] fieldbusStatusWord,
   // configuration
   input wire [DW-1:0] watchdogTimeoutSetting,
   input wire jogEnable,
   // drive state inputs
   input wire driveFault,
   input wire driveWarning,
   input wire modulating,
   input wire speedAtRef,
   input wire speedAboveLimit,
   // speed references
   input wire [REF_W-1:0] busSpeedRef,
   input wire [REF_W-1:0] jogRefOne,
   input wire [REF_W-1:0] jogRefTwo,
   output reg [REF_W-1:0] speedRef,
   // drive commands
   output reg runCmd,
   output reg coastStop,
   output reg quickStop,
   output reg faultReset,
   output reg busControlActive,
   output reg watchdogFault,
   // basic combination outputs
   output reg basicStart,
   output reg basicReverse,
   output reg basicFaultReset,
   output reg [4:0] busInputs
);
   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   // each bit is synchronised on its own: a word caught mid-change may show
   // a mix of old and new bits for one cycle, so the master must hold levels
   wire [15:0] cmdS;
   wire [15:0] basS;

   sync_bits #(.W(16)) u_sync_cmd (
      .clk(clk),
      .reset_n(reset_n),
      .din(commandWord),
      .dout(cmdS)
   );

   sync_bits #(.W(16)) u_sync_bas (
      .clk(clk),
      .reset_n(reset_n),
      .din(basicCommandWord),
      .dout(basS)
   );

   // ---------------------------------------------------------------
   // command decode
   // ---------------------------------------------------------------
   // previous synchronised word for edge detection; resets to the idle level
   reg [15:0] cmdOld_q;
   reg basResetOld_q;
   wire busEn = cmdS[`CMD_BUS_EN_BIT];
   // with bus control off the word is treated as all commands idle
   wire onCmd = busEn & cmdS[`CMD_ON_BIT];
   wire coastReq = busEn & ~cmdS[`CMD_COAST_N_BIT];
   wire quickReq = busEn & ~cmdS[`CMD_QSTOP_N_BIT];
   wire startReq = busEn & cmdS[`CMD_START_BIT];
   wire onRise = onCmd & ~cmdOld_q[`CMD_ON_BIT];
   wire ackRise = busEn & cmdS[`CMD_FLT_ACK_BIT] & ~cmdOld_q[`CMD_FLT_ACK_BIT];
   // one-cycle flag: fieldbus control withdrawn on this edge
   wire busDrop = ~busEn & cmdOld_q[`CMD_BUS_EN_BIT];
   wire basRise = basS[`BAS_RESET_BIT] & ~basResetOld_q;
   wire wdExpired;
   // either word may acknowledge faults; both share one reset path
   wire anyReset = ackRise | basRise;

   // the same fault reset that leaves the fault state clears the watchdog
   pulse_watchdog #(.DW(DW)) u_wdog (
      .clk(clk),
      .reset_n(reset_n),
      .pulse(cmdS[`CMD_WDOG_BIT]),
      .delayMs(watchdogTimeoutSetting),
      .clear(anyReset),
      .expired(wdExpired)
   );

   // ---------------------------------------------------------------
   // switch-on state machine
   // ---------------------------------------------------------------
   // one-hot state codes
   localparam [4:0] ST_INHIBIT = 5'h01;
   localparam [4:0] ST_RDY_ON = 5'h02;
   localparam [4:0] ST_RDY_RUN = 5'h04;
   localparam [4:0] ST_RUN = 5'h08;
   localparam [4:0] ST_FAULT = 5'h10;

   reg [4:0] state_q;
   reg [4:0] state_d;
   reg offSeen_q;
   reg offSeen_d;
   wire faultNow = driveFault | wdExpired;
   wire stopsFree = ~coastReq & ~quickReq;

   always @* begin
      state_d = state_q;
      offSeen_d = offSeen_q;
      case (state_q)
         ST_INHIBIT: begin
            // off must follow release of both stops before on is honoured
            if (!stopsFree)
               offSeen_d = 1'b0;
            else if (!onCmd)
               offSeen_d = 1'b1;
            if (offSeen_q && stopsFree && onRise) begin
               state_d = ST_RDY_RUN;
               offSeen_d = 1'b0;
            end
         end
         ST_RDY_ON: begin
            // off seen: only a fresh on edge brings the drive back
            if (onRise)
               state_d = ST_RDY_RUN;
         end
         ST_RDY_RUN: begin
            // dropping on outranks a start request in the same cycle
            if (!onCmd)
               state_d = ST_RDY_ON;
            else if (startReq)
               state_d = ST_RUN;
         end
         ST_RUN: begin
            // losing bus control while running must coast, not ramp
            if (busDrop)
               state_d = ST_INHIBIT;
            else if (!onCmd)
               state_d = ST_RDY_ON;
            else if (!startReq)
               state_d = ST_RDY_RUN;
         end
         ST_FAULT: begin
            // leaving needs the fault itself gone, not only the reset pulse
            if (anyReset && !driveFault)
               state_d = ST_INHIBIT;
         end
         default: begin
            // an illegal code falls back to the safest state
            state_d = ST_INHIBIT;
         end
      endcase
      // faults outrank stop requests, and both outrank the normal sequence
      if (state_q != ST_FAULT && faultNow)
         state_d = ST_FAULT;
      else if (state_q != ST_FAULT && (coastReq || quickReq))
         state_d = ST_INHIBIT;
   end

   always @(posedge clk) begin
      if (!reset_n) begin
         state_q <= ST_INHIBIT;
         offSeen_q <= 1'b0;
         cmdOld_q <= 16'h0000;
         basResetOld_q <= 1'b0;
      end else begin
         state_q <= state_d;
         offSeen_q <= offSeen_d;
         cmdOld_q <= cmdS;
         basResetOld_q <= basS[`BAS_RESET_BIT];
      end
   end

   // ---------------------------------------------------------------
   // status word
   // ---------------------------------------------------------------
   reg [15:0] status_q;
   reg [15:0] status_d;

   // state bits lag the command word by one cycle more than the level bits
   always @* begin
      status_d = `STATUS_RESET;
      status_d[`STS_RDY_ON_BIT] = (state_q == ST_RDY_ON);
      status_d[`STS_RDY_RUN_BIT] = (state_q == ST_RDY_RUN);
      status_d[`STS_RUN_BIT] = (state_q == ST_RUN) & modulating;
      status_d[`STS_FAULT_BIT] = (state_q == ST_FAULT);
      status_d[`STS_COAST_N_BIT] = ~coastReq;
      status_d[`STS_QSTOP_N_BIT] = ~quickReq;
      status_d[`STS_INHIBIT_BIT] = (state_q == ST_INHIBIT);
      status_d[`STS_WARN_BIT] = driveWarning;
      status_d[`STS_AT_REF_BIT] = speedAtRef;
      status_d[`STS_BUS_CTL_BIT] = busEn;
      status_d[`STS_ABOVE_BIT] = speedAboveLimit;
      status_d[`STS_WDOG_BIT] = cmdS[`CMD_WDOG_BIT];
   end

   // ---------------------------------------------------------------
   // status register
   // ---------------------------------------------------------------
   // registered so the master never reads a half-updated word
   always @(posedge clk) begin
      if (!reset_n) begin
         status_q <= `STATUS_RESET;
      end else begin
         status_q <= status_d;
      end
   end

   // ---------------------------------------------------------------
   // speed reference
   // ---------------------------------------------------------------
   // jogging is honoured only under fieldbus control and with its own enable;
   // both jog bits together select neither jog reference
   wire jog1 = busEn & jogEnable & cmdS[`CMD_JOG1_BIT] & ~cmdS[`CMD_JOG2_BIT];
   wire jog2 = busEn & jogEnable & cmdS[`CMD_JOG2_BIT] & ~cmdS[`CMD_JOG1_BIT];

   always @(posedge clk) begin
      if (!reset_n) begin
         speedRef <= {REF_W{1'b0}};
      end else begin
         if (jog1)
            speedRef <= jogRefOne;
         else if (jog2)
            speedRef <= jogRefTwo;
         else if (busEn)
            speedRef <= busSpeedRef;
         else
            speedRef <= {REF_W{1'b0}};
      end
   end

   // ---------------------------------------------------------------
   // drive commands
   // ---------------------------------------------------------------
   // the coast pulse on a control drop lasts one cycle; the drive latches it
   always @(posedge clk) begin
      if (!reset_n) begin
         runCmd <= 1'b0;
         coastStop <= 1'b0;
         quickStop <= 1'b0;
         faultReset <= 1'b0;
         busControlActive <= 1'b0;
         watchdogFault <= 1'b0;
      end else begin
         runCmd <= (state_q == ST_RUN);
         coastStop <= coastReq | (busDrop & (state_q == ST_RUN));
         quickStop <= quickReq;
         faultReset <= anyReset;
         busControlActive <= busEn;
         watchdogFault <= wdExpired;
      end
   end

   // ---------------------------------------------------------------
   // basic combination word
   // ---------------------------------------------------------------
   // this word bypasses the switch-on sequence and ignores bus control
   always @(posedge clk) begin
      if (!reset_n) begin
         basicStart <= 1'b0;
         basicReverse <= 1'b0;
         basicFaultReset <= 1'b0;
         busInputs <= 5'h00;
      end else begin
         basicStart <= basS[`BAS_START_BIT];
         basicReverse <= basS[`BAS_DIR_BIT];
         basicFaultReset <= basRise;
         busInputs <= basS[`BAS_DIN_MSB:`BAS_DIN_LSB];
         // bits 15..8 of the basic word are never read
      end
   end

   assign fieldbusStatusWord = status_q;
endmodule

// ---- src/fieldbus_cmd_regs.vh ----
`ifndef FIELDBUS_CMD_REGS_VH
`define FIELDBUS_CMD_REGS_VH

// full-profile command word bit positions
`define CMD_ON_BIT        0
`define CMD_COAST_N_BIT   1
`define CMD_QSTOP_N_BIT   2
`define CMD_START_BIT     3
`define CMD_FLT_ACK_BIT   7
`define CMD_JOG1_BIT      8
`define CMD_JOG2_BIT      9
`define CMD_BUS_EN_BIT    10
`define CMD_WDOG_BIT      11

// status word bit positions
`define STS_RDY_ON_BIT    0
`define STS_RDY_RUN_BIT   1
`define STS_RUN_BIT       2
`define STS_FAULT_BIT     3
`define STS_COAST_N_BIT   4
`define STS_QSTOP_N_BIT   5
`define STS_INHIBIT_BIT   6
`define STS_WARN_BIT      7
`define STS_AT_REF_BIT    8
`define STS_BUS_CTL_BIT   9
`define STS_ABOVE_BIT     10
`define STS_WDOG_BIT      15

// basic command word bit positions
`define BAS_START_BIT     0
`define BAS_DIR_BIT       1
`define BAS_RESET_BIT     2
`define BAS_DIN_LSB       3
`define BAS_DIN_MSB       7

// reset values
`define STATUS_RESET      16'h0000
`define WD_TIMER_RESET    32'h0000_0000

// timing: watchdog delay setting is in milliseconds
`define CLK_HZ            10000000
`define WD_UNIT_MS        1
`define CYC_PER_MS        ((`CLK_HZ / 1000) * `WD_UNIT_MS)

`endif

// ---- src/sync_bits.v ----
module sync_bits #(
   parameter W = 16
) (
   // clock and reset
   input wire clk,
   input wire reset_n,
   // data
   input wire [W-1:0] din,
   output wire [W-1:0] dout
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   always @(posedge clk) begin
      if (!reset_n) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end

   assign dout = sync_q;
endmodule

// ---- src/pulse_watchdog.v ----
`include "fieldbus_cmd_regs.vh"

module pulse_watchdog #(
   parameter DW = 16
) (
   // clock and reset
   input wire clk,
   input wire reset_n,
   // supervised pulse and setting
   input wire pulse,
   input wire [DW-1:0] delayMs,
   input wire clear,
   // result
   output wire expired
);
   // ---------------------------------------------------------------
   // toggle supervision
   // ---------------------------------------------------------------
   reg pulseOld_q;
   reg [31:0] cyc_q;
   reg [DW-1:0] ms_q;
   reg expired_q;
   wire edgeSeen = pulse ^ pulseOld_q;
   wire msTick = (cyc_q == `CYC_PER_MS - 1);

   always @(posedge clk) begin
      if (!reset_n) begin
         pulseOld_q <= 1'b0;
         cyc_q <= `WD_TIMER_RESET;
         ms_q <= {DW{1'b0}};
         expired_q <= 1'b0;
      end else begin
         pulseOld_q <= pulse;
         if (delayMs == {DW{1'b0}} || edgeSeen) begin
            cyc_q <= `WD_TIMER_RESET;
            ms_q <= {DW{1'b0}};
         end else if (msTick) begin
            cyc_q <= `WD_TIMER_RESET;
            if (ms_q != delayMs)
               ms_q <= ms_q + {{(DW-1){1'b0}}, 1'b1};
         end else begin
            cyc_q <= cyc_q + 32'h0000_0001;
         end
         // expiry is sticky; a new expiry in the clear cycle wins
         if (delayMs != {DW{1'b0}} && ms_q == delayMs && !edgeSeen)
            expired_q <= 1'b1;
         else if (clear)
            expired_q <= 1'b0;
      end
   end

   assign expired = expired_q;
endmodule

// ---- bench/drive_fieldbus_asserts.sv ----
module drive_fieldbus_asserts #(
   parameter REF_W = 16,
   parameter DW = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // words
   input wire logic [15:0] commandWord,
   input wire logic [15:0] basicCommandWord,
   input wire logic [15:0] fieldbusStatusWord,
   // drive levels
   input wire logic [DW-1:0] watchdogTimeoutSetting,
   input wire logic driveWarning,
   input wire logic speedAtRef,
   input wire logic speedAboveLimit,
   // decoded outputs
   input wire logic [REF_W-1:0] speedRef,
   input wire logic busControlActive,
   input wire logic watchdogFault,
   input wire logic basicStart,
   input wire logic basicReverse,
   input wire logic basicFaultReset,
   input wire logic [4:0] busInputs
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] warmCnt_q;
   wire warm = (warmCnt_q == 3'h5);
   // ----
   // warm-up: $past must not reach back into reset
   // ----
   always_ff @(posedge clk) begin
      if (!reset_n) warmCnt_q <= 3'h0;
      else if (!warm) warmCnt_q <= warmCnt_q + 3'h1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence basicRise;
      warm && !basicCommandWord[2] ##1 basicCommandWord[2];
   endsequence
   a_bus_ctl: assert property (warm |-> busControlActive == $past(commandWord[10], 3))
      else $error("bus control flag off");
   a_echo_pulse: assert property (warm |-> fieldbusStatusWord[15] == $past(commandWord[11], 3))
      else $error("pulse echo off");
   a_spare_zero: assert property (fieldbusStatusWord[14:11] == 4'h0)
      else $error("spare status bits set");
   a_basic_pass: assert property (warm |-> {busInputs, basicReverse, basicStart} ==
      {$past(basicCommandWord[7:3], 3), $past(basicCommandWord[1:0], 3)})
      else $error("basic word decode off");
   a_reset_edge: assert property (basicRise |-> ##3 basicFaultReset ##1 !basicFaultReset)
      else $error("fault reset pulse off");
   a_wd_shown: assert property ($rose(watchdogFault) |-> ##[0:3] fieldbusStatusWord[3])
      else $error("watchdog fault not shown");
   a_wd_off: assert property (!watchdogFault && ~|watchdogTimeoutSetting
      && ~|$past(watchdogTimeoutSetting) |=> !watchdogFault)
      else $error("fault with watchdog disabled");
   a_bus_off_ref: assert property (warm && !$past(commandWord[10], 3) |-> ~|speedRef)
      else $error("reference while bus disabled");
   a_drive_flags: assert property (warm |-> {fieldbusStatusWord[10], fieldbusStatusWord[8],
      fieldbusStatusWord[7]} == $past({speedAboveLimit, speedAtRef, driveWarning}))
      else $error("drive flags off");
endmodule

bind drive_fieldbus_command_status_word drive_fieldbus_asserts #(.REF_W(REF_W), .DW(DW)) chk (
   .clk, .reset_n, .commandWord, .basicCommandWord, .fieldbusStatusWord,
   .watchdogTimeoutSetting, .driveWarning, .speedAtRef, .speedAboveLimit, .speedRef,
   .busControlActive, .watchdogFault, .basicStart, .basicReverse, .basicFaultReset, .busInputs);

// ---- bench/fieldbus_master_model.sv ----
module fieldbus_master_model #(
   parameter int HALF = 2000
) (
   // clock
   input wire logic clk,
   // requested word and pulse enable
   input wire logic [15:0] wordReq,
   input wire logic toggleOn,
   // to the drive
   output logic [15:0] commandWord
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   logic pulse_q = 1'b0;
   // half period shortened from half a second to keep the run short
   always @(negedge clk) begin
      if (toggleOn) cnt = cnt + 1;
      if (cnt >= HALF) begin
         cnt = 0;
         pulse_q = ~pulse_q;
      end
   end
   assign commandWord = {wordReq[15:12], pulse_q, wordReq[10:0]};
endmodule

// ---- bench/drive_fieldbus_command_status_word_test.sv ----
module drive_fieldbus_command_status_word_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, reset_n = 1'b0, toggleOn = 1'b0, jogEnable = 1'b0, modulating = 1'b0;
   logic driveFault = 1'b0, driveWarning = 1'b0, speedAtRef = 1'b0, speedAboveLimit = 1'b0;
   logic [15:0] cmdReq = 16'h0000, basicCommandWord = 16'h0000, watchdogTimeoutSetting = 16'h0000;
   logic [15:0] busSpeedRef = 16'h1111, jogRefOne = 16'h2222, jogRefTwo = 16'h3333;
   logic [15:0] jogWord [4] = '{16'h0506, 16'h0606, 16'h0406, 16'h0106};
   logic [15:0] jogExp [4] = '{16'h2222, 16'h3333, 16'h1111, 16'h0000};
   logic [15:0] basWord [5] = '{16'h0000, 16'hFF04, 16'h00FB, 16'h0087, 16'h55AA};
   wire [15:0] commandWord, fieldbusStatusWord, speedRef;
   wire runCmd, coastStop, quickStop, faultReset, busControlActive, watchdogFault;
   wire basicStart, basicReverse, basicFaultReset;
   wire [4:0] busInputs;
   int errors = 0, comparisons = 0, pulses = 0, resets = 0, i;
   logic coastSeen = 1'b0;
   always #50 clk = ~clk;
   always @(posedge clk) begin
      if (coastStop) coastSeen <= 1'b1;
      if (basicFaultReset) pulses <= pulses + 1;
      if (faultReset) resets <= resets + 1;
   end
   fieldbus_master_model #(.HALF(2000)) master (.clk, .wordReq(cmdReq), .toggleOn, .commandWord);
   drive_fieldbus_command_status_word dut (.clk, .reset_n, .commandWord, .basicCommandWord,
      .fieldbusStatusWord, .watchdogTimeoutSetting, .jogEnable, .driveFault, .driveWarning,
      .modulating, .speedAtRef, .speedAboveLimit, .busSpeedRef, .jogRefOne, .jogRefTwo,
      .speedRef, .runCmd, .coastStop, .quickStop, .faultReset, .busControlActive,
      .watchdogFault, .basicStart, .basicReverse, .basicFaultReset, .busInputs);
   // ----
   // access and compare tasks, entered at a falling edge
   // ----
   task put_cmd(input logic [15:0] v);
      cmdReq = v;
      repeat (6) @(negedge clk);
   endtask
   task put_basic(input logic [15:0] v);
      basicCommandWord = v;
      repeat (6) @(negedge clk);
   endtask
   task chk_word(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task chk_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %0t bit %b expected %b", $time, got, exp);
      end
   endtask
   task stop_test;
      if (errors == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      stop_test();
   end
   initial begin
      repeat (16) @(negedge clk);
      reset_n = 1'b1;
      repeat (2) @(negedge clk);
      chk_word(fieldbusStatusWord, 16'h0070);
      put_cmd(16'h0406);
      chk_word(fieldbusStatusWord, 16'h0270);
      put_cmd(16'h0407);
      chk_word(fieldbusStatusWord, 16'h0232);
      put_cmd(16'h0406);
      chk_word(fieldbusStatusWord, 16'h0231);
      put_cmd(16'h0407);
      modulating = 1'b1;
      put_cmd(16'h040F);
      chk_bit(fieldbusStatusWord[2], 1'b1);
      chk_bit(runCmd, 1'b1);
      put_cmd(16'h000F);
      chk_bit(coastSeen, 1'b1);
      chk_bit(runCmd, 1'b0);
      put_cmd(16'h0403);
      chk_bit(quickStop, 1'b1);
      chk_bit(fieldbusStatusWord[5], 1'b0);
      put_cmd(16'h0405);
      chk_bit(coastStop, 1'b1);
      chk_bit(fieldbusStatusWord[4], 1'b0);
      put_cmd(16'h0407);
      chk_word(fieldbusStatusWord, 16'h0270);
      put_cmd(16'h0506);
      chk_word(speedRef, 16'h1111);
      jogEnable = 1'b1;
      for (i = 0; i < 4; i++) begin
         put_cmd(jogWord[i]);
         chk_word(speedRef, jogExp[i]);
      end
      {driveWarning, speedAtRef, speedAboveLimit, driveFault} = 4'hF;
      repeat (4) @(negedge clk);
      chk_word({13'h0000, fieldbusStatusWord[10], fieldbusStatusWord[8],
         fieldbusStatusWord[7]}, 16'h0007);
      chk_bit(fieldbusStatusWord[3], 1'b1);
      {driveWarning, speedAtRef, speedAboveLimit, driveFault} = 4'h0;
      for (i = 0; i < 5; i++) begin
         put_basic(basWord[i]);
         chk_word({9'h000, busInputs, basicReverse, basicStart},
            {9'h000, basWord[i][7:3], basWord[i][1:0]});
      end
      chk_word(16'(pulses), 16'h0002);
      chk_word(16'(resets), 16'h0002);
      chk_bit(fieldbusStatusWord[3], 1'b0);
      chk_bit(fieldbusStatusWord[7], 1'b0);
      watchdogTimeoutSetting = 16'h0001;
      toggleOn = 1'b1;
      repeat (12000) @(negedge clk);
      chk_bit(watchdogFault, 1'b0);
      toggleOn = 1'b0;
      repeat (10100) @(negedge clk);
      chk_bit(watchdogFault, 1'b1);
      chk_bit(fieldbusStatusWord[3], 1'b1);
      watchdogTimeoutSetting = 16'h0000;
      put_basic(16'h0000);
      put_basic(16'h0004);
      chk_bit(watchdogFault, 1'b0);
      repeat (12000) @(negedge clk);
      chk_bit(watchdogFault, 1'b0);
      stop_test();
   end
endmodule
